// File: design/scan_cmd_pkg.sv
// Constants and types shared by the scan command handler
package scan_cmd_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_RESP = 8'h08;
   localparam logic [7:0] A_NOISE = 8'h0c;
   localparam logic [7:0] A_INIT_MASS = 8'h10;
   localparam logic [7:0] A_FINAL_MASS = 8'h14;
   localparam logic [7:0] A_STEPS = 8'h18;
   // Command word fields
   localparam int OP_LSB = 0;
   localparam int KIND_LSB = 4;
   localparam int FRAC_BIT = 6;
   localparam int VAL_LSB = 8;
   localparam int VAL_W = 16;
   // Opcodes
   localparam logic [2:0] OP_NOISE = 3'h1;
   localparam logic [2:0] OP_ANALOG_PTS = 3'h2;
   localparam logic [2:0] OP_HIST_PTS = 3'h3;
   localparam logic [2:0] OP_HIST_SCAN = 3'h4;
   // Parameter kinds
   localparam logic [1:0] PK_NONE = 2'h0;
   localparam logic [1:0] PK_NUM = 2'h1;
   localparam logic [1:0] PK_DEF = 2'h2;
   localparam logic [1:0] PK_QRY = 2'h3;
   // Status bit positions
   localparam int ST_SCAN_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_CONT_BIT = 2;
   localparam int ST_REM_LSB = 8;
   // Ranges and defaults
   localparam int MASS_W = 9;
   localparam int STEPS_W = 5;
   localparam int BUF_AW = 9;
   localparam int BUF_DEPTH = 512;
   localparam logic [15:0] NOISE_MAX = 16'h0007;
   localparam logic [2:0] NOISE_DEF = 3'h4;
   localparam logic [15:0] SCAN_CNT_MAX = 16'h00ff;
   localparam logic [7:0] SCAN_CNT_DEF = 8'h01;
   localparam logic [8:0] INIT_MASS_DEF = 9'h001;
   localparam logic [8:0] FINAL_MASS_DEF = 9'h064;
   localparam logic [4:0] STEPS_DEF = 5'h0a;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_DRAIN = 3'h1,
      S_ZERO = 3'h2,
      S_MEAS = 3'h3,
      S_TP = 3'h4
   } scan_state_t;
endpackage : scan_cmd_pkg

// File: design/scan_command_handler.sv
// Scan command handler: noise floor, point-count queries, histogram scans
`timescale 1ns/1ps
module scan_command_handler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic det_sel,
   output logic scan_det,
   output logic [2:0] noise_floor,
   output logic zero_req,
   input wire logic zero_done,
   output logic meas_req,
   output logic meas_tp,
   output logic [8:0] meas_mass,
   input wire logic meas_ack,
   input wire logic [31:0] meas_data,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready
);

   typedef struct packed {
      scan_cmd_pkg::scan_state_t st;
      logic [2:0] noise;
      logic [8:0] init_mass;
      logic [8:0] final_mass;
      logic [4:0] steps;
      logic err;
      logic [15:0] resp;
      logic [7:0] remaining;
      logic cont;
      logic det;
      logic [8:0] mass;
      logic zero_req;
      logic meas_req;
      logic tp;
      logic [9:0] wr;
      logic [9:0] rd;
      logic [31:0] word;
      logic busy;
      logic [1:0] byte_idx;
      logic [31:0] rdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [31:0] buf_mem [scan_cmd_pkg::BUF_DEPTH];
   logic buf_we;
   logic cmd_wr;
   logic [2:0] op;
   logic [1:0] kind;
   logic frac;
   logic [15:0] val;
   logic [15:0] hist_pts;
   logic [15:0] analog_pts;
   logic [8:0] span;

   // Integer parameter within an inclusive upper bound
   function automatic logic num_ok(input logic [15:0] v, input logic f, input logic [15:0] hi);
      num_ok = !f && (v <= hi);
   endfunction : num_ok

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == scan_cmd_pkg::A_CMD) || (a == scan_cmd_pkg::A_STATUS) ||
         (a == scan_cmd_pkg::A_RESP) || (a == scan_cmd_pkg::A_NOISE) ||
         (a == scan_cmd_pkg::A_INIT_MASS) || (a == scan_cmd_pkg::A_FINAL_MASS) ||
         (a == scan_cmd_pkg::A_STEPS);
   endfunction : addr_known

   assign op = pwdata[scan_cmd_pkg::OP_LSB +: 3];
   assign kind = pwdata[scan_cmd_pkg::KIND_LSB +: 2];
   assign frac = pwdata[scan_cmd_pkg::FRAC_BIT];
   assign val = pwdata[scan_cmd_pkg::VAL_LSB +: scan_cmd_pkg::VAL_W];
   assign cmd_wr = psel && penable && pwrite && (paddr == scan_cmd_pkg::A_CMD);
   assign span = s_r.final_mass - s_r.init_mass;
   assign hist_pts = {7'h00, span} + 16'h0001;
   assign analog_pts = 16'({7'h00, span} * {11'h000, s_r.steps}) + 16'h0001;

   always_comb begin
      s_nxt = s_r;
      buf_we = 1'b0;
      // Registered read data: latched in the setup phase so no wait state is needed
      if (psel && !penable) begin
         case (paddr)
            scan_cmd_pkg::A_STATUS: s_nxt.rdata = {16'h0000, s_r.remaining, 5'h00, s_r.cont,
               s_r.err, (s_r.st != scan_cmd_pkg::S_IDLE)};
            scan_cmd_pkg::A_RESP: s_nxt.rdata = {16'h0000, s_r.resp};
            scan_cmd_pkg::A_NOISE: s_nxt.rdata = {29'h0, s_r.noise};
            scan_cmd_pkg::A_INIT_MASS: s_nxt.rdata = {23'h0, s_r.init_mass};
            scan_cmd_pkg::A_FINAL_MASS: s_nxt.rdata = {23'h0, s_r.final_mass};
            scan_cmd_pkg::A_STEPS: s_nxt.rdata = {27'h0, s_r.steps};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // Byte serialiser, low byte first
      if (s_r.busy && tx_ready) begin
         s_nxt.byte_idx = s_r.byte_idx + 2'h1;
         if (s_r.byte_idx == 2'h3) begin
            s_nxt.busy = 1'b0;
         end
      end
      if (!s_nxt.busy && (s_r.rd != s_r.wr)) begin
         s_nxt.word = buf_mem[s_r.rd[8:0]];
         s_nxt.rd = s_r.rd + 10'h001;
         s_nxt.busy = 1'b1;
         s_nxt.byte_idx = 2'h0;
      end
      case (s_r.st)
         scan_cmd_pkg::S_DRAIN: begin
            // Buffer holds one whole scan; never mix two scans in it
            if ((s_r.wr == s_r.rd) && !s_r.busy) begin
               s_nxt.st = scan_cmd_pkg::S_ZERO;
               s_nxt.zero_req = 1'b1;
               s_nxt.wr = 10'h000;
               s_nxt.rd = 10'h000;
            end
         end
         scan_cmd_pkg::S_ZERO: begin
            if (zero_done) begin
               s_nxt.zero_req = 1'b0;
               s_nxt.st = scan_cmd_pkg::S_MEAS;
               s_nxt.mass = s_r.init_mass;
               s_nxt.meas_req = 1'b1;
            end
         end
         scan_cmd_pkg::S_MEAS: begin
            if (meas_ack) begin
               buf_we = 1'b1;
               s_nxt.wr = s_r.wr + 10'h001;
               if (s_r.mass >= s_r.final_mass) begin
                  s_nxt.st = scan_cmd_pkg::S_TP;
                  s_nxt.tp = 1'b1;
               end else begin
                  s_nxt.mass = s_r.mass + 9'h001;
               end
            end
         end
         scan_cmd_pkg::S_TP: begin
            if (meas_ack) begin
               buf_we = 1'b1;
               s_nxt.wr = s_r.wr + 10'h001;
               s_nxt.meas_req = 1'b0;
               s_nxt.tp = 1'b0;
               if (s_r.cont) begin
                  s_nxt.st = scan_cmd_pkg::S_DRAIN;
               end else if (s_r.remaining <= 8'h01) begin
                  s_nxt.st = scan_cmd_pkg::S_IDLE;
                  s_nxt.remaining = 8'h00;
               end else begin
                  s_nxt.remaining = s_r.remaining - 8'h01;
                  s_nxt.st = scan_cmd_pkg::S_DRAIN;
               end
            end
         end
         default: ;
      endcase
      if (psel && penable && pwrite) begin
         case (paddr)
            scan_cmd_pkg::A_INIT_MASS: s_nxt.init_mass = pwdata[8:0];
            scan_cmd_pkg::A_FINAL_MASS: s_nxt.final_mass = pwdata[8:0];
            scan_cmd_pkg::A_STEPS: s_nxt.steps = pwdata[4:0];
            default: ;
         endcase
      end
      if (cmd_wr) begin
         // Abort and flush first; the new command then acts on a clean state
         buf_we = 1'b0;
         s_nxt.st = scan_cmd_pkg::S_IDLE;
         s_nxt.zero_req = 1'b0;
         s_nxt.meas_req = 1'b0;
         s_nxt.tp = 1'b0;
         s_nxt.wr = 10'h000;
         s_nxt.rd = 10'h000;
         s_nxt.busy = 1'b0;
         s_nxt.byte_idx = 2'h0;
         s_nxt.cont = 1'b0;
         s_nxt.remaining = 8'h00;
         s_nxt.err = 1'b0;
         case (op)
            scan_cmd_pkg::OP_NOISE: begin
               case (kind)
                  scan_cmd_pkg::PK_NUM: begin
                     if (num_ok(val, frac, scan_cmd_pkg::NOISE_MAX)) begin
                        s_nxt.noise = val[2:0];
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  scan_cmd_pkg::PK_DEF: s_nxt.noise = scan_cmd_pkg::NOISE_DEF;
                  scan_cmd_pkg::PK_QRY: s_nxt.resp = {13'h0000, s_r.noise};
                  default: s_nxt.err = 1'b1;
               endcase
            end
            scan_cmd_pkg::OP_ANALOG_PTS: begin
               if (kind == scan_cmd_pkg::PK_QRY) begin
                  s_nxt.resp = analog_pts;
               end else begin
                  s_nxt.err = 1'b1;
               end
            end
            scan_cmd_pkg::OP_HIST_PTS: begin
               if (kind == scan_cmd_pkg::PK_QRY) begin
                  s_nxt.resp = hist_pts;
               end else begin
                  s_nxt.err = 1'b1;
               end
            end
            scan_cmd_pkg::OP_HIST_SCAN: begin
               s_nxt.det = det_sel;
               case (kind)
                  scan_cmd_pkg::PK_NONE: begin
                     s_nxt.cont = 1'b1;
                     s_nxt.st = scan_cmd_pkg::S_DRAIN;
                  end
                  scan_cmd_pkg::PK_NUM: begin
                     if (!num_ok(val, frac, scan_cmd_pkg::SCAN_CNT_MAX)) begin
                        s_nxt.err = 1'b1;
                     end else if (val != 16'h0000) begin
                        s_nxt.remaining = val[7:0];
                        s_nxt.st = scan_cmd_pkg::S_DRAIN;
                     end
                  end
                  scan_cmd_pkg::PK_DEF: begin
                     s_nxt.remaining = scan_cmd_pkg::SCAN_CNT_DEF;
                     s_nxt.st = scan_cmd_pkg::S_DRAIN;
                  end
                  default: s_nxt.err = 1'b1;
               endcase
            end
            default: s_nxt.err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.st <= scan_cmd_pkg::S_IDLE;
         s_r.noise <= scan_cmd_pkg::NOISE_DEF;
         s_r.init_mass <= scan_cmd_pkg::INIT_MASS_DEF;
         s_r.final_mass <= scan_cmd_pkg::FINAL_MASS_DEF;
         s_r.steps <= scan_cmd_pkg::STEPS_DEF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Scan buffer: no reset, contents only matter between write and read pointers
   always_ff @(posedge pclk) begin
      if (buf_we) begin
         buf_mem[s_r.wr[8:0]] <= meas_data;
      end
   end

   assign prdata = s_r.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_known(paddr);
   assign scan_det = s_r.det;
   assign noise_floor = s_r.noise;
   assign zero_req = s_r.zero_req;
   assign meas_req = s_r.meas_req;
   assign meas_tp = s_r.tp;
   assign meas_mass = s_r.mass;
   assign tx_valid = s_r.busy;
   assign tx_data = s_r.word[{s_r.byte_idx, 3'h0} +: 8];

   AST_NOISE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_NUM && val > 16'h0007
      |=> s_r.err && $stable(noise_floor))
      else $error("noise floor accepted an out-of-range value");
   AST_NOISE_SET: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_NUM && !frac
      && val <= 16'h0007 |=> noise_floor == $past(pwdata[scan_cmd_pkg::VAL_LSB +: 3]))
      else $error("noise floor did not take a legal value");
   AST_NOISE_FRAC: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_NUM && frac
      |=> s_r.err && $stable(noise_floor))
      else $error("noise floor accepted a fractional value");
   AST_NOISE_RESET: assert property (@(posedge pclk)
      $rose(presetn) |-> noise_floor == 3'h4)
      else $error("noise floor not at default after reset");
   AST_NOISE_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_DEF
      |=> noise_floor == 3'h4)
      else $error("noise floor default marker did not load four");
   AST_NOISE_QUERY: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_QRY
      |=> s_r.resp == {13'h0000, $past(noise_floor)})
      else $error("noise floor query answer wrong");
   AST_NOISE_NONE: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_NOISE && kind == scan_cmd_pkg::PK_NONE
      |=> s_r.err && noise_floor == $past(noise_floor))
      else $error("bare noise floor command not rejected");
   AST_NOISE_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
      !cmd_wr |=> $stable(noise_floor))
      else $error("noise floor moved without a command");
   AST_ANALOG_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_ANALOG_PTS && kind == scan_cmd_pkg::PK_QRY
      |=> s_r.resp == ({7'h00, $past(s_r.final_mass) - $past(s_r.init_mass)}
      * {11'h000, $past(s_r.steps)}) + 16'h0001)
      else $error("analog point count wrong");
   AST_HIST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_PTS && kind == scan_cmd_pkg::PK_QRY
      |=> s_r.resp == 16'($past(s_r.final_mass) - $past(s_r.init_mass)) + 16'h0001)
      else $error("histogram point count wrong");
   AST_PTS_BAD: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && (op == scan_cmd_pkg::OP_ANALOG_PTS || op == scan_cmd_pkg::OP_HIST_PTS)
      && kind != scan_cmd_pkg::PK_QRY |=> s_r.err)
      else $error("point query accepted a bad parameter");
   AST_SCAN_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN && kind == scan_cmd_pkg::PK_NUM && !frac
      && val != 16'h0000 && val <= 16'h00ff |=> s_r.st == scan_cmd_pkg::S_DRAIN
      && s_r.remaining == $past(pwdata[scan_cmd_pkg::VAL_LSB +: 8]))
      else $error("scan count not loaded");
   AST_SCAN_CONT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN && kind == scan_cmd_pkg::PK_NONE
      |=> s_r.cont && s_r.st == scan_cmd_pkg::S_DRAIN)
      else $error("bare scan trigger not continuous");
   AST_SCAN_DEF: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN && kind == scan_cmd_pkg::PK_DEF
      |=> s_r.remaining == 8'h01 && s_r.st == scan_cmd_pkg::S_DRAIN)
      else $error("default scan trigger not a single scan");
   AST_SCAN_BAD: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN && (kind == scan_cmd_pkg::PK_QRY
      || (kind == scan_cmd_pkg::PK_NUM && (frac || val > 16'h00ff)))
      |=> s_r.err && s_r.st == scan_cmd_pkg::S_IDLE)
      else $error("bad scan trigger accepted");
   AST_FIRST_MASS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(meas_req) |-> meas_mass == s_r.init_mass)
      else $error("scan did not start at the initial mass");
   AST_MASS_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      s_r.st == scan_cmd_pkg::S_MEAS && meas_ack && !cmd_wr && meas_mass < s_r.final_mass
      |=> meas_mass == $past(meas_mass) + 9'h001)
      else $error("mass did not step by one");
   AST_DET_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN |=> scan_det == $past(det_sel))
      else $error("scan detector not taken at trigger");
   AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr |=> !tx_valid && !meas_req && s_r.wr == s_r.rd)
      else $error("command did not abort scan and flush");
   AST_SCAN_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_wr && op == scan_cmd_pkg::OP_HIST_SCAN && kind == scan_cmd_pkg::PK_NUM
      && val == 16'h0000 && !frac |=> (s_r.st == scan_cmd_pkg::S_IDLE) [*2])
      else $error("zero scan trigger started activity");
   AST_DRAIN_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(zero_req) |-> $past(s_r.wr) == $past(s_r.rd) && !$past(tx_valid))
      else $error("scan started with data pending");
   AST_ZERO_BEFORE_MEAS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(meas_req) |-> $past(zero_req) && $past(zero_done))
      else $error("measurement started without zero correction");
   AST_TP_LAST: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(meas_tp) |-> $past(meas_ack) && $past(meas_mass) >= s_r.final_mass)
      else $error("total pressure not after final mass");
   AST_BYTES: assert property (@(posedge pclk) disable iff (!presetn)
      tx_valid && tx_ready && s_r.byte_idx == 2'h3 && !cmd_wr |=> s_r.byte_idx == 2'h0)
      else $error("point not four bytes long");

endmodule : scan_command_handler

// File: dv/scan_host_model.sv
// Behavioural model of the measurement front end and the serial sink
`timescale 1ns/1ps
module scan_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic zero_req,
   output logic zero_done,
   input wire logic meas_req,
   input wire logic meas_tp,
   input wire logic [8:0] meas_mass,
   output logic meas_ack,
   output logic [31:0] meas_data,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [3:0] cnt_r;
   logic [1:0] tick_r;
   logic [7:0] rx_q[$];
   // Negative codes put a sign byte on the wire; total pressure has its own pattern
   function automatic logic [31:0] cur(input logic [8:0] m, input logic tp);
      cur = tp ? 32'h7e5a_0c01 : (32'hff80_0000 | {23'h0, m});
   endfunction : cur
   // A slow host stalls the transmitter half of the time
   assign tx_ready = !(slow && tick_r[1]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         tick_r <= 2'h0;
         zero_done <= 1'b0;
         meas_ack <= 1'b0;
         meas_data <= 32'h0;
      end else begin
         tick_r <= tick_r + 2'h1;
         zero_done <= 1'b0;
         meas_ack <= 1'b0;
         // Data only means something with the ack; otherwise it keeps changing
         meas_data <= ~meas_data;
         if ((zero_req || meas_req) && !zero_done && !meas_ack) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r >= (slow ? 4'h5 : 4'h1)) begin
               cnt_r <= 4'h0;
               zero_done <= zero_req;
               meas_ack <= meas_req && !zero_req;
               meas_data <= cur(meas_mass, meas_tp);
            end
         end else begin
            cnt_r <= 4'h0;
         end
      end
   end
   always @(posedge pclk) begin
      if (tx_valid && tx_ready) begin
         rx_q.push_back(tx_data);
      end
   end
endmodule : scan_host_model

// File: dv/scan_command_handler_tb_top.sv
// Self-checking bench for the scan command handler
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); bad_count++; end end
module scan_command_handler_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, det_sel = 1'b0, slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err_q, scan_det, zero_req, zero_done, meas_req, meas_tp, meas_ack;
   logic tx_valid, tx_ready, zr_q;
   logic [2:0] noise_floor;
   logic [8:0] meas_mass;
   logic [31:0] meas_data;
   logic [7:0] tx_data;
   int bad_count = 0, samples_checked = 0, cyc = 0, zcount = 0, overlap = 0, n;
   always #10 pclk = ~pclk;
   scan_command_handler scan_command_handler_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .det_sel, .scan_det, .noise_floor,
      .zero_req, .zero_done, .meas_req, .meas_tp, .meas_mass, .meas_ack, .meas_data,
      .tx_data, .tx_valid, .tx_ready);
   scan_host_model host_i (.pclk, .presetn, .slow, .zero_req, .zero_done, .meas_req,
      .meas_tp, .meas_mass, .meas_ack, .meas_data, .tx_data, .tx_valid, .tx_ready);
   always @(posedge pclk) begin
      zr_q <= zero_req;
      if (zero_req === 1'b1 && zr_q === 1'b0) zcount++;
      if (zero_req === 1'b1 && tx_valid === 1'b1) overlap++;
      cyc++;
      if (cyc > 40000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input logic [2:0] op, input logic [1:0] k, input logic [15:0] v,
      input logic f);
      apb(1'b1, scan_cmd_pkg::A_CMD, {8'h00, v, 1'b0, f, k, 1'b0, op});
   endtask : cmd
   task automatic st_err(input logic e);
      apb(1'b0, scan_cmd_pkg::A_STATUS, 32'h0);
      `CHK("err", e, q[scan_cmd_pkg::ST_ERR_BIT])
   endtask : st_err
   task automatic wait_done;
      for (n = 0; n < 4000; n++) begin
         apb(1'b0, scan_cmd_pkg::A_STATUS, 32'h0);
         if (q[0] === 1'b0 && tx_valid === 1'b0) break;
      end
      // Let the host model take the last byte of this edge first
      @(negedge pclk);
   endtask : wait_done
   // Expects ns scans of mi..mf plus the trailing pressure word, low byte first
   task automatic chk_scans(input int ns, input int lo, input int hi);
      int k;
      logic [31:0] w;
      k = 0;
      `CHK("bytes", ns * (hi - lo + 2) * 4, host_i.rx_q.size())
      for (int s = 0; s < ns; s++) begin
         for (int m = lo; m <= hi + 1; m++) begin
            w = {host_i.rx_q[k+3], host_i.rx_q[k+2], host_i.rx_q[k+1], host_i.rx_q[k]};
            `CHK("word", host_i.cur(m[8:0], m > hi), w)
            k += 4;
         end
      end
      host_i.rx_q.delete();
   endtask : chk_scans
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, scan_cmd_pkg::A_NOISE, 32'h0);
      `CHK("floor_reset", 32'h4, q)
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_NUM, 16'h7, 1'b0);
      @(negedge pclk);
      `CHK("floor_port", 3'h7, noise_floor)
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_NUM, 16'h8, 1'b0);
      st_err(1'b1);
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_NUM, 16'h3, 1'b1);
      st_err(1'b1);
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_NONE, 16'h2, 1'b0);
      st_err(1'b1);
      apb(1'b0, scan_cmd_pkg::A_NOISE, 32'h0);
      `CHK("floor_kept", 32'h7, q)
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_DEF, 16'h0, 1'b0);
      @(negedge pclk);
      `CHK("floor_def", 3'h4, noise_floor)
      cmd(scan_cmd_pkg::OP_NOISE, scan_cmd_pkg::PK_QRY, 16'h0, 1'b0);
      apb(1'b0, scan_cmd_pkg::A_RESP, 32'h0);
      `CHK("floor_query", 16'h4, q[15:0])
      apb(1'b1, scan_cmd_pkg::A_INIT_MASS, 32'h3);
      apb(1'b1, scan_cmd_pkg::A_FINAL_MASS, 32'h6);
      apb(1'b1, scan_cmd_pkg::A_STEPS, 32'hc);
      cmd(scan_cmd_pkg::OP_ANALOG_PTS, scan_cmd_pkg::PK_QRY, 16'h0, 1'b0);
      apb(1'b0, scan_cmd_pkg::A_RESP, 32'h0);
      `CHK("analog_pts", 16'h25, q[15:0])
      cmd(scan_cmd_pkg::OP_HIST_PTS, scan_cmd_pkg::PK_QRY, 16'h0, 1'b0);
      apb(1'b0, scan_cmd_pkg::A_RESP, 32'h0);
      `CHK("hist_pts", 16'h4, q[15:0])
      for (int k = 0; k < 6; k++) begin
         cmd(k < 3 ? scan_cmd_pkg::OP_ANALOG_PTS : scan_cmd_pkg::OP_HIST_PTS, 2'(k % 3),
            16'h1, 1'b0);
         st_err(1'b1);
      end
      det_sel <= 1'b1;
      slow <= 1'b1;
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NUM, 16'h2, 1'b0);
      det_sel <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK("scan_det", 1'b1, scan_det)
      wait_done();
      chk_scans(2, 3, 6);
      `CHK("zero_runs", 2, zcount)
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_DEF, 16'h0, 1'b0);
      wait_done();
      chk_scans(1, 3, 6);
      `CHK("overlap", 0, overlap)
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_QRY, 16'h0, 1'b0);
      st_err(1'b1);
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NUM, 16'h100, 1'b0);
      st_err(1'b1);
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NUM, 16'h2, 1'b1);
      st_err(1'b1);
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NUM, 16'h0, 1'b0);
      repeat (40) @(posedge pclk);
      `CHK("hs0_bytes", 0, host_i.rx_q.size())
      slow <= 1'b0;
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NONE, 16'h0, 1'b0);
      for (n = 0; n < 2000 && host_i.rx_q.size() < 60; n++) @(posedge pclk);
      apb(1'b0, scan_cmd_pkg::A_STATUS, 32'h0);
      `CHK("continuous", 1'b1, q[scan_cmd_pkg::ST_CONT_BIT])
      cmd(scan_cmd_pkg::OP_HIST_SCAN, scan_cmd_pkg::PK_NUM, 16'h0, 1'b0);
      @(negedge pclk);
      `CHK("abort_tx", 1'b0, tx_valid)
      `CHK("abort_meas", 1'b0, meas_req | zero_req)
      n = host_i.rx_q.size();
      repeat (50) @(posedge pclk);
      `CHK("abort_bytes", n, host_i.rx_q.size())
      host_i.rx_q.delete();
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err_q, q})
      test_done();
   end
endmodule : scan_command_handler_tb_top
